// ===== design/cpu_addr_pkg.sv
// Constants, modes and clock counts for operand and branch address generation.
// Assumes a 16-bit address space and one core clock.
package cpu_addr_pkg;

  typedef enum logic [3:0] {
    MODE_REG = 4'h0,
    MODE_SHORT = 4'h1,
    MODE_SFR = 4'h2,
    MODE_IND = 4'h3,
    MODE_PAIR_IND = 4'h4,
    MODE_INDEX = 4'h5,
    MODE_STACK = 4'h6,
    MODE_SEQ = 4'h7,
    MODE_REL = 4'h8,
    MODE_IMM = 4'h9,
    MODE_FIXED = 4'hA,
    MODE_TABLE = 4'hB,
    MODE_RPAIR = 4'hC,
    MODE_SHIFT = 4'hD
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TABLE = 2'h1
  } state_t;

  // Data memory map
  localparam logic [15:0] REG_BANK_BASE = 16'hFEE0;
  localparam logic [15:0] IND_BASE = 16'hFE00;
  localparam logic [15:0] RAM_LO = 16'hFE40;
  localparam logic [15:0] RAM_HI = 16'hFEFF;
  localparam logic [15:0] SFR_BASE = 16'hFF00;
  localparam logic [15:0] SHORT_SFR_HI = 16'hFF1F;
  localparam logic [7:0] SHORT_SFR_SPAN = 8'h20;
  localparam logic [7:0] SHORT_RAM_OFF = 8'h40;
  localparam logic [2:0] PAIR_THREE = 3'h3;
  localparam logic [2:0] AUTOINC_REG = 3'h4;

  // Instruction address map
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] LONG_HI = 16'h3FFF;
  localparam logic [15:0] REL_HI = 16'h1FFF;
  localparam logic [15:0] FIXED_BASE = 16'h0800;
  localparam logic [15:0] FIXED_HI = 16'h0FFF;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] TABLE_HI = 16'h007E;

  // Clock counts
  localparam logic [4:0] CLK_REG = 5'h02;
  localparam logic [4:0] CLK_SHORT = 5'h03;
  localparam logic [4:0] CLK_SFR = 5'h05;
  localparam logic [4:0] CLK_IND = 5'h05;
  localparam logic [4:0] CLK_IND_INC = 5'h06;
  localparam logic [4:0] CLK_PAIR = 5'h05;
  localparam logic [4:0] CLK_PAIR_SFR = 5'h07;
  localparam logic [4:0] CLK_IDX = 5'h07;
  localparam logic [4:0] CLK_IDX_OVF = 5'h08;
  localparam logic [4:0] CLK_IDX_SFR = 5'h09;
  localparam logic [4:0] CLK_IDX_SFR_OVF = 5'h0A;
  localparam logic [4:0] CLK_STACK = 5'h04;
  localparam logic [4:0] CLK_SEQ = 5'h02;
  localparam logic [4:0] CLK_REL = 5'h04;
  localparam logic [4:0] CLK_REL_NT = 5'h03;
  localparam logic [4:0] CLK_IMM = 5'h03;
  localparam logic [4:0] CLK_FIXED = 5'h05;
  localparam logic [4:0] CLK_TABLE = 5'h06;
  localparam logic [4:0] CLK_RPAIR = 5'h04;
  localparam logic [4:0] CLK_SHIFT_BASE = 5'h02;

endpackage

// ===== design/reg_locate.sv
// Maps register and pair codes to their data-memory location in the active bank.
// Assumes codes and bank flags come from the decoder on the same clock.
module reg_locate
  import cpu_addr_pkg::*;
(
  // Bank choice
  input wire logic bank_select_low_flag,
  input wire logic bank_select_high_flag,
  // Codes
  input wire logic [2:0] reg_code,
  input wire logic [1:0] pair_code,
  // Locations
  output logic [15:0] reg_loc,
  output logic [15:0] pair_loc
);

  // Eight bytes per bank; X,A,C,B,E,D,L,H in code order, so pair p sits at 2p
  wire [15:0] bank_base;
  assign bank_base = REG_BANK_BASE
    + {11'h0, bank_select_high_flag, bank_select_low_flag, 3'h0};
  assign reg_loc = bank_base + {13'h0, reg_code};
  assign pair_loc = bank_base + {13'h0, pair_code, 1'b0};

endmodule

// ===== design/clock_count.sv
// Clock count for one instruction, from its mode and the adjustment conditions.
// Assumes all inputs are settled combinationally in the cycle of the request.
module clock_count
  import cpu_addr_pkg::*;
(
  // Mode and conditions
  input wire mode_t mode,
  input wire logic sfr_hit,
  input wire logic idx_ovf,
  input wire logic autoinc,
  input wire logic not_taken,
  input wire logic [2:0] shift_n,
  // Result
  output logic [4:0] clocks
);

  always_comb begin
    unique case (mode)
      MODE_REG: clocks = CLK_REG;
      MODE_SHORT: clocks = CLK_SHORT;
      MODE_SFR: clocks = CLK_SFR;
      MODE_IND: clocks = autoinc ? CLK_IND_INC : CLK_IND;
      MODE_PAIR_IND: clocks = sfr_hit ? CLK_PAIR_SFR : CLK_PAIR;
      MODE_INDEX: begin
        if (sfr_hit) begin
          clocks = idx_ovf ? CLK_IDX_SFR_OVF : CLK_IDX_SFR;
        end else begin
          clocks = idx_ovf ? CLK_IDX_OVF : CLK_IDX;
        end
      end
      MODE_STACK: clocks = CLK_STACK;
      MODE_REL: clocks = not_taken ? CLK_REL_NT : CLK_REL;
      MODE_IMM: clocks = CLK_IMM;
      MODE_FIXED: clocks = CLK_FIXED;
      MODE_TABLE: clocks = CLK_TABLE;
      MODE_RPAIR: clocks = CLK_RPAIR;
      MODE_SHIFT: clocks = CLK_SHIFT_BASE + {2'h0, shift_n};
      default: clocks = CLK_SEQ;
    endcase
  end

endmodule

// ===== design/cpu_address_generation.sv
// Operand and program-counter address generation for the core.
// Assumes requests, register values and table reads come from core logic on ref_clk.
module cpu_address_generation
  import cpu_addr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Request from the decoder
  input wire logic req_valid,
  input wire mode_t req_mode,
  input wire logic [2:0] req_reg_code,
  input wire logic [1:0] req_pair_code,
  input wire logic [15:0] req_imm16,
  input wire logic [2:0] req_len,
  input wire logic req_word,
  input wire logic req_is_move,
  input wire logic req_autoinc,
  input wire logic req_cond,
  input wire logic req_taken,
  input wire logic [2:0] req_shift_n,
  // Status word flags
  input wire logic bank_select_low_flag,
  input wire logic bank_select_high_flag,
  // Operand values from the register file
  input wire logic [7:0] op_reg_val,
  input wire logic [15:0] op_pair_val,
  input wire logic [15:0] sp_val,
  // Table read data, valid while tbl_rd is high
  input wire logic [15:0] tbl_data,
  // Operand address result
  output logic done,
  output logic data_valid,
  output logic [15:0] data_addr,
  output logic word_access,
  output logic addr_err,
  output logic [4:0] clocks,
  // Auto-increment request
  output logic inc_strobe,
  output logic [15:0] inc_loc,
  // Program counter
  output logic [15:0] pc_out,
  output logic pc_load,
  // Table read
  output logic tbl_rd,
  output logic [15:0] tbl_addr,
  output logic busy
);

  state_t state_reg;
  logic done_reg, data_valid_reg, word_reg, err_reg, inc_reg, pc_load_reg, tbl_rd_reg;
  logic [15:0] data_addr_reg, inc_loc_reg, pc_reg, tbl_addr_reg;
  logic [4:0] clocks_reg;
  logic [15:0] reg_loc, pair_loc, addr_next, pc_next;
  logic err_next, data_next;
  logic [4:0] clocks_next;

  wire take = req_valid && state_reg == ST_IDLE;
  wire [7:0] off = req_imm16[7:0];

  reg_locate u_loc (
    .bank_select_low_flag(bank_select_low_flag),
    .bank_select_high_flag(bank_select_high_flag),
    .reg_code(req_reg_code),
    .pair_code(req_pair_code),
    .reg_loc(reg_loc),
    .pair_loc(pair_loc)
  );

  // Short and special-register decode
  wire short_sfr = off < SHORT_SFR_SPAN;
  wire [15:0] short_addr = (short_sfr ? SFR_BASE : IND_BASE) | {8'h0, off};
  wire short_err = (!short_sfr && off < SHORT_RAM_OFF) || (req_word && off[0]);
  wire [15:0] sfr_addr = SFR_BASE | {8'h0, off};

  // Register indirect; the low page of the window holds nothing usable
  wire [15:0] ind_addr = IND_BASE | {8'h0, op_reg_val};
  wire ind_err = ind_addr < RAM_LO;
  wire do_inc = req_mode == MODE_IND && req_is_move && req_autoinc
    && req_reg_code == AUTOINC_REG;

  // Pair three indirect, full 16-bit reach
  wire pair_err = {1'b0, req_pair_code} != PAIR_THREE;

  // Indexed sum; carry out of bit 15 is the overflow case
  wire [16:0] idx_sum = {1'b0, req_imm16} + {9'h0, op_reg_val};
  wire idx_ovf = idx_sum[16];

  // Stack pointer window
  wire stack_err = sp_val < RAM_LO || sp_val > RAM_HI;

  // Program counter targets
  wire [15:0] seq_pc = pc_reg + {13'h0, req_len};
  wire [15:0] rel_pc = seq_pc + {{8{req_imm16[7]}}, req_imm16[7:0]};
  wire rel_err = rel_pc > REL_HI;
  wire not_taken = req_cond && !req_taken;
  wire [15:0] long_pc = {2'h0, req_imm16[13:0]};
  wire [15:0] fixed_pc = FIXED_BASE | {5'h0, req_imm16[10:0]};
  wire [15:0] tbl_entry = TABLE_BASE + {10'h0, req_imm16[4:0], 1'b0};

  wire sfr_hit = (req_mode == MODE_INDEX ? idx_sum[15:0] : op_pair_val) >= SFR_BASE;

  clock_count u_clk (
    .mode(req_mode),
    .sfr_hit(sfr_hit),
    .idx_ovf(idx_ovf),
    .autoinc(do_inc),
    .not_taken(not_taken),
    .shift_n(req_shift_n),
    .clocks(clocks_next)
  );

  // Mode selection of operand address and next program counter
  always_comb begin
    addr_next = 16'h0000;
    err_next = 1'b0;
    data_next = 1'b1;
    pc_next = seq_pc;
    unique case (req_mode)
      MODE_REG: addr_next = reg_loc;
      MODE_SHORT: begin
        addr_next = short_addr;
        err_next = short_err;
      end
      MODE_SFR: addr_next = sfr_addr;
      MODE_IND: begin
        addr_next = ind_addr;
        err_next = ind_err;
      end
      MODE_PAIR_IND: begin
        addr_next = op_pair_val;
        err_next = pair_err;
      end
      MODE_INDEX: addr_next = idx_sum[15:0];
      MODE_STACK: begin
        addr_next = sp_val;
        err_next = stack_err;
      end
      MODE_REL: begin
        data_next = 1'b0;
        if (!not_taken) begin
          pc_next = rel_pc;
          err_next = rel_err;
        end
      end
      MODE_IMM: begin
        data_next = 1'b0;
        pc_next = long_pc;
      end
      MODE_FIXED: begin
        data_next = 1'b0;
        pc_next = fixed_pc;
      end
      MODE_TABLE: data_next = 1'b0;
      MODE_RPAIR: begin
        data_next = 1'b0;
        pc_next = op_pair_val;
      end
      default: data_next = 1'b0;
    endcase
  end

  // Sequencer: a table call waits one cycle for its entry
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      tbl_rd_reg <= 1'b0;
      tbl_addr_reg <= 16'h0000;
    end else begin
      tbl_rd_reg <= take && req_mode == MODE_TABLE;
      if (take && req_mode == MODE_TABLE) begin
        state_reg <= ST_TABLE;
        tbl_addr_reg <= tbl_entry;
      end else begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // Program counter; loaded at the end of the request so the next fetch sees it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= PC_RESET;
      pc_load_reg <= 1'b0;
    end else begin
      pc_load_reg <= 1'b0;
      if (state_reg == ST_TABLE) begin
        pc_reg <= tbl_data;
        pc_load_reg <= 1'b1;
      end else if (take && req_mode != MODE_TABLE) begin
        pc_reg <= pc_next;
        pc_load_reg <= 1'b1;
      end
    end
  end

  // Operand results
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
      data_valid_reg <= 1'b0;
      data_addr_reg <= 16'h0000;
      word_reg <= 1'b0;
      err_reg <= 1'b0;
      clocks_reg <= 5'h00;
    end else begin
      done_reg <= (take && req_mode != MODE_TABLE) || state_reg == ST_TABLE;
      data_valid_reg <= take && data_next;
      if (take) begin
        data_addr_reg <= addr_next;
        word_reg <= req_word;
        err_reg <= err_next;
        clocks_reg <= clocks_next;
      end
    end
  end

  // Increment request to the register file
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inc_reg <= 1'b0;
      inc_loc_reg <= 16'h0000;
    end else begin
      inc_reg <= take && do_inc;
      if (take && do_inc) begin
        inc_loc_reg <= reg_loc;
      end
    end
  end

  assign done = done_reg;
  assign data_valid = data_valid_reg;
  assign data_addr = data_addr_reg;
  assign word_access = word_reg;
  assign addr_err = err_reg;
  assign clocks = clocks_reg;
  assign inc_strobe = inc_reg;
  assign inc_loc = inc_loc_reg;
  assign pc_out = pc_reg;
  assign pc_load = pc_load_reg;
  assign tbl_rd = tbl_rd_reg;
  assign tbl_addr = tbl_addr_reg;
  assign busy = tbl_rd_reg;

  chk_bank_location: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_REG |=> data_addr == REG_BANK_BASE
      + {11'h0, $past(bank_select_high_flag), $past(bank_select_low_flag), 3'h0}
      + {13'h0, $past(req_reg_code)})
    else $error("register location wrong");

  chk_short_window: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_SHORT |=> addr_err || (data_addr >= RAM_LO && data_addr <= RAM_HI)
      || (data_addr >= SFR_BASE && data_addr <= SHORT_SFR_HI))
    else $error("short address outside windows");

  chk_word_even: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_SHORT && req_word && req_imm16[0] |=> addr_err && word_access)
    else $error("odd word start not flagged");

  chk_sfr_base: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_SFR |=> data_addr == {8'hFF, $past(req_imm16[7:0])})
    else $error("special register address wrong");

  chk_inc_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    inc_strobe |-> $past(req_mode) == MODE_IND && $past(req_is_move)
      && $past(req_reg_code) == 3'h4 && $past(req_autoinc))
    else $error("increment without cause");

  chk_index_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_INDEX && idx_ovf && !sfr_hit |=> clocks == CLK_IDX_OVF)
    else $error("overflow count missing");

  chk_pair_sfr: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_PAIR_IND && op_pair_val >= SFR_BASE |=> clocks == CLK_PAIR_SFR)
    else $error("special register count missing");

  chk_seq_advance: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_SEQ |=> pc_load && pc_out == $past(pc_reg) + {13'h0, $past(req_len)})
    else $error("sequential advance wrong");

  chk_not_taken: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_REL && not_taken |=> clocks == CLK_REL_NT
      && pc_out == $past(seq_pc))
    else $error("not-taken branch wrong");

  chk_fixed_area: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_FIXED |=> pc_out >= FIXED_BASE && pc_out <= FIXED_HI
      && pc_out[10:0] == $past(req_imm16[10:0]))
    else $error("fixed call outside area");

  chk_table_call: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tbl_rd |-> tbl_addr >= TABLE_BASE && tbl_addr <= TABLE_HI && !tbl_addr[0]
      ##1 pc_load && done && pc_out == $past(tbl_data))
    else $error("table call wrong");

  chk_long_target: assert property (@(posedge ref_clk) disable iff (!arst_n)
    take && req_mode == MODE_IMM |=> pc_out <= LONG_HI
      && pc_out[13:0] == $past(req_imm16[13:0]))
    else $error("long target out of range");

  // Pair locations have no output of their own, so guard the map here
  chk_pair_location: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pair_loc == REG_BANK_BASE + {11'h0, bank_select_high_flag, bank_select_low_flag, 3'h0}
      + {13'h0, req_pair_code, 1'b0})
    else $error("pair location wrong");

endmodule

// ===== tb/cpu_address_generation_tb.sv
// Self-checking bench for operand and program-counter address generation.
// Assumes the design package and modules are compiled first; one core clock.
module cpu_address_generation_tb
  import cpu_addr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  mode_t req_mode = MODE_REG;
  logic [2:0] req_reg_code = 3'h0;
  logic [1:0] req_pair_code = 2'h0;
  logic [15:0] req_imm16 = 16'h0000;
  logic [2:0] req_len = 3'h1;
  logic req_word = 1'b0;
  logic req_is_move = 1'b0;
  logic req_autoinc = 1'b0;
  logic req_cond = 1'b0;
  logic req_taken = 1'b1;
  logic [2:0] req_shift_n = 3'h0;
  logic bank_select_low_flag = 1'b0;
  logic bank_select_high_flag = 1'b0;
  logic [7:0] op_reg_val = 8'h00;
  logic [15:0] op_pair_val = 16'h0000;
  logic [15:0] sp_val = 16'h0000;
  logic [15:0] tbl_data = 16'h0000;
  logic done, data_valid, word_access, addr_err, inc_strobe, pc_load, tbl_rd, busy;
  logic [15:0] data_addr, inc_loc, pc_out, tbl_addr;
  logic [4:0] clocks;
  int fail_count = 0;
  int check_count = 0;

  cpu_address_generation dut_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid), .req_mode(req_mode),
    .req_reg_code(req_reg_code), .req_pair_code(req_pair_code), .req_imm16(req_imm16),
    .req_len(req_len), .req_word(req_word), .req_is_move(req_is_move),
    .req_autoinc(req_autoinc), .req_cond(req_cond), .req_taken(req_taken),
    .req_shift_n(req_shift_n), .bank_select_low_flag(bank_select_low_flag),
    .bank_select_high_flag(bank_select_high_flag), .op_reg_val(op_reg_val),
    .op_pair_val(op_pair_val), .sp_val(sp_val), .tbl_data(tbl_data), .done(done),
    .data_valid(data_valid), .data_addr(data_addr), .word_access(word_access),
    .addr_err(addr_err), .clocks(clocks), .inc_strobe(inc_strobe), .inc_loc(inc_loc),
    .pc_out(pc_out), .pc_load(pc_load), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr), .busy(busy)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bit_is(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask

  // One request, dropped after its take edge; bounded wait for done
  task automatic go(input mode_t m, input logic [15:0] imm);
    int i;
    @(negedge ref_clk);
    req_mode = m;
    req_imm16 = imm;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (i = 0; i < 4 && done !== 1'b1; i++) begin
      @(negedge ref_clk);
    end
    bit_is(done, 1'b1);
  endtask

  task automatic expect_data(input logic [15:0] addr, input logic [4:0] clk, input logic err);
    check(data_addr, addr);
    check({11'h000, clocks}, {11'h000, clk});
    bit_is(addr_err, err);
    bit_is(data_valid, 1'b1);
  endtask

  task automatic expect_pc(input logic [15:0] pc, input logic [4:0] clk, input logic err);
    check(pc_out, pc);
    check({11'h000, clocks}, {11'h000, clk});
    bit_is(addr_err, err);
    bit_is(pc_load, 1'b1);
  endtask

  task automatic t_reg;
    int b;
    int c;
    for (b = 0; b < 4; b++) begin
      for (c = 0; c < 8; c++) begin
        {bank_select_high_flag, bank_select_low_flag} = b[1:0];
        req_reg_code = c[2:0];
        go(MODE_REG, 16'h0000);
        expect_data(16'hFEE0 + 16'(8 * b + c), 5'h02, 1'b0);
      end
    end
  endtask

  task automatic t_short;
    int i;
    logic [7:0] off;
    logic err;
    logic [7:0] offs [7] = '{8'h00, 8'h1F, 8'h40, 8'hFF, 8'h20, 8'h40, 8'h41};
    for (i = 0; i < 7; i++) begin
      off = offs[i];
      req_word = (i >= 5);
      err = (off >= 8'h20 && off < 8'h40) || (req_word && off[0]);
      go(MODE_SHORT, {8'h00, off});
      bit_is(addr_err, err);
      if (!err) begin
        expect_data((off < 8'h20) ? {8'hFF, off} : {8'hFE, off}, 5'h03, 1'b0);
        bit_is(word_access, req_word);
      end
    end
    req_word = 1'b0;
    go(MODE_SFR, 16'h0000);
    expect_data(16'hFF00, 5'h05, 1'b0);
    go(MODE_SFR, 16'h005E);
    expect_data(16'hFF5E, 5'h05, 1'b0);
  endtask

  // Increment only for move plus marker plus register 4
  task automatic t_ind;
    {bank_select_high_flag, bank_select_low_flag} = 2'b10;
    req_reg_code = 3'h4;
    op_reg_val = 8'h50;
    go(MODE_IND, 16'h0000);
    expect_data(16'hFE50, 5'h05, 1'b0);
    bit_is(inc_strobe, 1'b0);
    req_is_move = 1'b1;
    req_autoinc = 1'b1;
    go(MODE_IND, 16'h0000);
    expect_data(16'hFE50, 5'h06, 1'b0);
    bit_is(inc_strobe, 1'b1);
    check(inc_loc, 16'hFEF4);
    req_reg_code = 3'h5;
    go(MODE_IND, 16'h0000);
    expect_data(16'hFE50, 5'h05, 1'b0);
    bit_is(inc_strobe, 1'b0);
    req_is_move = 1'b0;
    req_reg_code = 3'h4;
    go(MODE_IND, 16'h0000);
    bit_is(inc_strobe, 1'b0);
    req_autoinc = 1'b0;
    op_reg_val = 8'h3F;
    go(MODE_IND, 16'h0000);
    bit_is(addr_err, 1'b1);
  endtask

  task automatic t_pair_index_stack;
    req_pair_code = 2'h3;
    op_pair_val = 16'h0123;
    go(MODE_PAIR_IND, 16'h0000);
    expect_data(16'h0123, 5'h05, 1'b0);
    op_pair_val = 16'hFF10;
    go(MODE_PAIR_IND, 16'h0000);
    expect_data(16'hFF10, 5'h07, 1'b0);
    req_pair_code = 2'h1;
    go(MODE_PAIR_IND, 16'h0000);
    bit_is(addr_err, 1'b1);
    op_reg_val = 8'h20;
    go(MODE_INDEX, 16'h1000);
    expect_data(16'h1020, 5'h07, 1'b0);
    go(MODE_INDEX, 16'hFFF0);
    expect_data(16'h0010, 5'h08, 1'b0);
    op_reg_val = 8'h05;
    go(MODE_INDEX, 16'hFF00);
    expect_data(16'hFF05, 5'h09, 1'b0);
    sp_val = 16'hFE40;
    go(MODE_STACK, 16'h0000);
    expect_data(16'hFE40, 5'h04, 1'b0);
    sp_val = 16'hFF00;
    go(MODE_STACK, 16'h0000);
    bit_is(addr_err, 1'b1);
  endtask

  task automatic t_branch;
    go(MODE_IMM, 16'hF234);
    expect_pc(16'h3234, 5'h03, 1'b0);
    req_len = 3'h3;
    go(MODE_SEQ, 16'h0000);
    expect_pc(16'h3237, 5'h02, 1'b0);
    bit_is(data_valid, 1'b0);
    req_len = 3'h2;
    go(MODE_IMM, 16'h0100);
    go(MODE_REL, 16'h0080);
    expect_pc(16'h0082, 5'h04, 1'b0);
    req_cond = 1'b1;
    req_taken = 1'b0;
    go(MODE_REL, 16'h0080);
    expect_pc(16'h0084, 5'h03, 1'b0);
    req_taken = 1'b1;
    go(MODE_REL, 16'h007F);
    expect_pc(16'h0105, 5'h04, 1'b0);
    go(MODE_IMM, 16'h1FF0);
    go(MODE_REL, 16'h007F);
    bit_is(addr_err, 1'b1);
    req_cond = 1'b0;
    go(MODE_FIXED, 16'hFFFF);
    expect_pc(16'h0FFF, 5'h05, 1'b0);
    go(MODE_FIXED, 16'h0000);
    expect_pc(16'h0800, 5'h05, 1'b0);
    op_pair_val = 16'hABCD;
    go(MODE_RPAIR, 16'h0000);
    expect_pc(16'hABCD, 5'h04, 1'b0);
  endtask

  task automatic t_shift;
    int n;
    for (n = 0; n < 8; n++) begin
      req_shift_n = n[2:0];
      go(MODE_SHIFT, 16'h0000);
      check({11'h000, clocks}, 16'(2 + n));
    end
  endtask

  // A request held during the table read must be dropped
  task automatic t_table;
    int k;
    for (k = 0; k < 2; k++) begin
      tbl_data = k ? 16'h2468 : 16'h1357;
      @(negedge ref_clk);
      req_mode = MODE_TABLE;
      req_imm16 = k ? 16'h001F : 16'h0000;
      req_valid = 1'b1;
      @(negedge ref_clk);
      req_mode = MODE_IMM;
      req_imm16 = 16'h0ABC;
      bit_is(tbl_rd, 1'b1);
      bit_is(busy, 1'b1);
      check(tbl_addr, k ? 16'h007E : 16'h0040);
      bit_is(done, 1'b0);
      @(negedge ref_clk);
      req_valid = 1'b0;
      bit_is(done, 1'b1);
      expect_pc(tbl_data, 5'h06, 1'b0);
      @(negedge ref_clk);
      bit_is(done, 1'b0);
      check(pc_out, tbl_data);
    end
  endtask

  task automatic t_reset_mid;
    @(negedge ref_clk);
    arst_n = 1'b0;
    #1;
    check(pc_out, 16'h0000);
    bit_is(busy, 1'b0);
    @(negedge ref_clk);
    arst_n = 1'b1;
    req_len = 3'h1;
    go(MODE_SEQ, 16'h0000);
    expect_pc(16'h0001, 5'h02, 1'b0);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(pc_out, 16'h0000);
    bit_is(done, 1'b0);
    arst_n = 1'b1;
    t_reg;
    t_short;
    t_ind;
    t_pair_index_stack;
    t_branch;
    t_shift;
    t_table;
    t_reset_mid;
    report_and_stop;
  end

  // Whole run is under two hundred cycles; generous margin
  initial begin
    #50000;
    fail_count++;
    report_and_stop;
  end
endmodule
